// >>> core/seq_pkg.sv
// Package: register map, field layout and constants of the sequencer
package seq_pkg;

   // ----------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------
   localparam logic [7:0] OFS_FEEDBACK = 8'h04;
   localparam logic [7:0] OFS_EXC_SETUP = 8'h08;
   localparam logic [7:0] OFS_TIME_LIMIT = 8'h10;
   localparam logic [7:0] OFS_SLOT_0_1 = 8'h20;
   localparam logic [7:0] OFS_SLOT_4_5 = 8'h24;
   localparam logic [7:0] OFS_SLOT_2_3 = 8'h28;
   localparam logic [7:0] OFS_SLOT_6_7 = 8'h2c;
   localparam logic [7:0] OFS_SLOT_8 = 8'h30;

   // ----------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------
   localparam logic [31:0] RST_SLOT_0_1 = 32'h012600df;
   localparam logic [31:0] RST_SLOT_4_5 = 32'h012600de;
   localparam logic [31:0] RST_SLOT_2_3 = 32'h012700de;
   localparam logic [31:0] RST_SLOT_6_7 = 32'h012600df;
   localparam logic [31:0] RST_SLOT_8 = 32'h000000de;
   localparam logic [12:0] RST_EXC_SETUP = 13'h0000;
   localparam logic [7:0] RST_TIME_LIMIT = 8'h00;

   // ----------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------
   localparam int EVEN_LSB = 0;
   localparam int ODD_LSB = 16;
   localparam int FB_CHAN_LSB = 16;
   localparam int FB_SLOT_LSB = 11;
   localparam int FB_BUSY_BIT = 9;
   localparam int FB_HALT_BIT = 8;
   localparam int EX_SEL_BIT = 12;
   localparam int EX_EN_BIT = 11;
   localparam int EX_REP_LSB = 8;

   // ----------------------------------------------------------
   // Codes and counts
   // ----------------------------------------------------------
   localparam logic [3:0] NUM_SLOTS = 4'h9;
   localparam logic [3:0] LAST_SLOT = 4'h8;
   localparam logic [3:0] LAST_CHAN = 4'h8;
   localparam logic [3:0] CODE_STARTUP = 4'h9;
   localparam logic [3:0] CODE_EMPTY_MASKED = 4'hb;
   localparam logic [3:0] CODE_SUSPEND = 4'hc;
   localparam logic [3:0] CODE_NONE = 4'h0;
   localparam logic [8:0] TIME_EXTRA = 9'h002;
   localparam logic [5:0] CONV_CYCLES = 6'h20;

   typedef struct packed {
      logic sel;
      logic en;
      logic [2:0] repeat_count_field;
      logic [3:0] chan;
   } exc_setup_t;

   typedef struct packed {
      logic [3:0] chan;
      logic [3:0] slot;
      logic busy;
      logic halted;
      logic [3:0] cause;
   } feedback_t;

endpackage

// >>> core/swm_timer.sv
// Software-mode duration counter
`timescale 1ns/1ps
module swm_timer
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Control
   input wire logic start_in,
   input wire logic [7:0] limit_in,
   // Status
   output logic active_out,
   output logic done_out
);
   logic [8:0] count_q;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         count_q <= 9'h000;
      end
      else if (start_in && limit_in != 8'h00 && count_q == 9'h000)
      begin
         count_q <= {1'b0, limit_in} + seq_pkg::TIME_EXTRA;
      end
      else if (count_q != 9'h000)
      begin
         count_q <= count_q - 9'h001;
      end
   end

   assign active_out = (count_q != 9'h000);
   assign done_out = (count_q == 9'h001);
endmodule

// >>> core/measurement_channel_sequencer.sv
// Channel sequencer of the measurement converter with APB registers
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Paired slot registers hold even mask 8:0 and odd mask 24:16
// - Ninth slot register holds mask 8:0, bits 31:9 read zero
// - Walk slots 0 to 8, each mask from MSB to LSB, skip clears
// - Slot masks change only on privileged or trim accesses
// - Feedback 19:16 reports the channel under conversion; in exceptional runs code shows chan_q, not the exceptional channel
// - Feedback 14:11 reports active slot, 1001 during startup
// - Feedback bit 9 shows exceptional measurement in progress
// - Feedback bit 8 shows sequencer halted in software mode
// - Feedback 3:0 gives cause slot, 1011 empty masked, 1100 suspend
// - No empty-after-masking code when time limit is zero
// - Trigger select: zero timer input, one charge-pump clock
// - Triggers start exceptional measurement only when enabled
// - Repeat field gives two to the power conversions
// - Repeat zero: one conversion, continue while trigger high
// - Setup bits 3:0 choose exceptional channel 0 to 8
// - Software mode lasts time limit plus two cycles
// - Time limit zero never enters software mode; max 257
module measurement_channel_sequencer
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [2:0] pprot_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Trim path, privileged mask load
   input wire logic trim_en_in,
   // Trigger pins and system
   input wire logic timer_trig_in,
   input wire logic pump_clk_in,
   input wire logic suspend_in,
   input wire logic swm_req_in,
   input wire logic [8:0] swm_mask_in,
   // Converter handshake
   input wire logic conv_done_in,
   output logic soc_out,
   output logic [3:0] mux_chan_out,
   output logic exc_busy_out,
   output logic postproc_halted_out
);
   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_STARTUP = 2'b00,
      ST_NORMAL = 2'b01,
      ST_EXC = 2'b11,
      ST_SWM = 2'b10
   } state_t;

   state_t state_q;
   logic [8:0] mask_q [0:8];
   seq_pkg::exc_setup_t exc_q;
   logic [7:0] limit_q;
   logic [3:0] slot_q;
   logic [3:0] chan_q;
   logic [3:0] cause_q;
   logic [7:0] exc_left_q;
   logic conv_wait_q;
   logic soc_q;
   logic [2:0] trig_sync_q;
   logic [2:0] pump_sync_q;
   logic [1:0] susp_sync_q;
   logic [1:0] swreq_sync_q;
   logic trig_lvl;
   logic trig_rise;
   logic wr_en;
   logic priv_wr;
   logic [8:0] cur_mask;
   logic [8:0] lower_bits;
   logic [3:0] next_chan;
   logic [3:0] next_slot;
   logic found;
   logic swm_start;
   logic swm_active;
   logic swm_done;
   logic [8:0] masked;
   seq_pkg::feedback_t fb;

   // ----------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         trig_sync_q <= 3'h0;
         pump_sync_q <= 3'h0;
         susp_sync_q <= 2'h0;
         swreq_sync_q <= 2'h0;
      end
      else
      begin
         trig_sync_q <= {trig_sync_q[1:0], timer_trig_in};
         pump_sync_q <= {pump_sync_q[1:0], pump_clk_in};
         susp_sync_q <= {susp_sync_q[0], suspend_in};
         swreq_sync_q <= {swreq_sync_q[0], swm_req_in};
      end
   end

   always_comb
   begin
      if (exc_q.sel)
      begin
         trig_lvl = pump_sync_q[1];
         trig_rise = pump_sync_q[1] && !pump_sync_q[2];
      end
      else
      begin
         trig_lvl = trig_sync_q[1];
         trig_rise = trig_sync_q[1] && !trig_sync_q[2];
      end
   end

   // ----------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------
   assign wr_en = psel_in && penable_in && pwrite_in;
   assign priv_wr = wr_en && (pprot_in[0] || trim_en_in);
   assign pready_out = 1'b1;

   always_comb
   begin
      pslverr_out = 1'b0;
      if (psel_in && penable_in)
      begin
         case (paddr_in)
            seq_pkg::OFS_FEEDBACK: pslverr_out = pwrite_in;
            seq_pkg::OFS_EXC_SETUP, seq_pkg::OFS_TIME_LIMIT: ;
            seq_pkg::OFS_SLOT_0_1, seq_pkg::OFS_SLOT_2_3,
            seq_pkg::OFS_SLOT_4_5, seq_pkg::OFS_SLOT_6_7,
            seq_pkg::OFS_SLOT_8: pslverr_out = pwrite_in && !priv_wr;
            default: pslverr_out = 1'b1;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < 9; g++)
      begin : gen_mask
         localparam logic [7:0] OFS = (g == 8) ? seq_pkg::OFS_SLOT_8 :
            (g < 2) ? seq_pkg::OFS_SLOT_0_1 :
            (g < 4) ? seq_pkg::OFS_SLOT_2_3 :
            (g < 6) ? seq_pkg::OFS_SLOT_4_5 : seq_pkg::OFS_SLOT_6_7;
         localparam logic [31:0] RST = (g == 8) ? seq_pkg::RST_SLOT_8 :
            (g < 2) ? seq_pkg::RST_SLOT_0_1 :
            (g < 4) ? seq_pkg::RST_SLOT_2_3 :
            (g < 6) ? seq_pkg::RST_SLOT_4_5 : seq_pkg::RST_SLOT_6_7;
         localparam int LSB = (g % 2 == 1) ? seq_pkg::ODD_LSB :
            seq_pkg::EVEN_LSB;
         always_ff @(posedge clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
            begin
               mask_q[g] <= RST[LSB +: 9];
            end
            else if (priv_wr && paddr_in == OFS)
            begin
               mask_q[g] <= pwdata_in[LSB +: 9];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         exc_q <= seq_pkg::RST_EXC_SETUP[8:0];
         limit_q <= seq_pkg::RST_TIME_LIMIT;
      end
      else if (wr_en && paddr_in == seq_pkg::OFS_EXC_SETUP)
      begin
         exc_q <= {pwdata_in[12:8], pwdata_in[3:0]};
      end
      else if (wr_en && paddr_in == seq_pkg::OFS_TIME_LIMIT)
      begin
         limit_q <= pwdata_in[7:0];
      end
   end

   assign fb.chan = chan_q;
   assign fb.slot = (state_q == ST_STARTUP) ?
      seq_pkg::CODE_STARTUP : slot_q;
   assign fb.busy = (state_q == ST_EXC);
   assign fb.halted = swm_active;
   assign fb.cause = cause_q;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         prdata_out <= 32'h00000000;
      end
      else if (psel_in && !penable_in && !pwrite_in)
      begin
         case (paddr_in)
            seq_pkg::OFS_FEEDBACK: prdata_out <= {12'h000, fb.chan,
               1'b0, fb.slot, 1'b0, fb.busy, fb.halted, 4'h0, fb.cause};
            seq_pkg::OFS_EXC_SETUP: prdata_out <= {19'h00000,
               exc_q.sel, exc_q.en, exc_q.repeat_count_field, 4'h0, exc_q.chan};
            seq_pkg::OFS_TIME_LIMIT: prdata_out <= {24'h000000, limit_q};
            seq_pkg::OFS_SLOT_0_1: prdata_out <= {7'h00, mask_q[1],
               7'h00, mask_q[0]};
            seq_pkg::OFS_SLOT_2_3: prdata_out <= {7'h00, mask_q[3],
               7'h00, mask_q[2]};
            seq_pkg::OFS_SLOT_4_5: prdata_out <= {7'h00, mask_q[5],
               7'h00, mask_q[4]};
            seq_pkg::OFS_SLOT_6_7: prdata_out <= {7'h00, mask_q[7],
               7'h00, mask_q[6]};
            seq_pkg::OFS_SLOT_8: prdata_out <= {23'h000000, mask_q[8]};
            default: prdata_out <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Next enabled channel search
   // ----------------------------------------------------------
   assign cur_mask = mask_q[slot_q];

   always_comb
   begin
      lower_bits = 9'h000;
      next_chan = chan_q;
      next_slot = slot_q;
      found = 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         if (i < chan_q)
         begin
            lower_bits[i] = cur_mask[i];
         end
      end
      for (int i = 0; i < 9; i++)
      begin
         if (lower_bits[i])
         begin
            next_chan = 4'(i);
            found = 1'b1;
         end
      end
      if (!found)
      begin
         next_slot = (slot_q == seq_pkg::LAST_SLOT) ? 4'h0 :
            slot_q + 4'h1;
         for (int i = 0; i < 9; i++)
         begin
            if (mask_q[next_slot][i])
            begin
               next_chan = 4'(i);
            end
         end
         if (mask_q[next_slot] == 9'h000)
         begin
            next_chan = seq_pkg::LAST_CHAN + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------
   // Software mode
   // ----------------------------------------------------------
   assign masked = cur_mask & ~swm_mask_in;
   // A trigger wins over a halt request in the same cycle
   assign swm_start = swreq_sync_q[1] && state_q == ST_NORMAL &&
      !(exc_q.en && trig_rise) &&
      masked != 9'h000 && limit_q != 8'h00;

   swm_timer u_swm_timer
   (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .start_in(swm_start),
      .limit_in(limit_q),
      .active_out(swm_active),
      .done_out(swm_done)
   );

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cause_q <= seq_pkg::CODE_NONE;
      end
      else if (susp_sync_q[1])
      begin
         cause_q <= seq_pkg::CODE_SUSPEND;
      end
      else if (swm_start)
      begin
         cause_q <= slot_q;
      end
      else if (swreq_sync_q[1] && state_q == ST_NORMAL &&
         masked == 9'h000 && limit_q != 8'h00)
      begin
         cause_q <= seq_pkg::CODE_EMPTY_MASKED;
      end
   end

   // ----------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_q <= ST_STARTUP;
         slot_q <= seq_pkg::LAST_SLOT;
         chan_q <= 4'h0;
         exc_left_q <= 8'h00;
         conv_wait_q <= 1'b0;
         soc_q <= 1'b0;
      end
      else
      begin
         soc_q <= 1'b0;
         case (state_q)
            ST_STARTUP:
            begin
               chan_q <= 4'h0;
               state_q <= ST_NORMAL;
            end
            ST_NORMAL:
            begin
               // Running conversion finishes inside the exceptional state
               if (exc_q.en && trig_rise)
               begin
                  state_q <= ST_EXC;
                  exc_left_q <= 8'h01 << exc_q.repeat_count_field;
               end
               else if (swm_start)
               begin
                  state_q <= ST_SWM;
               end
               else if (conv_wait_q)
               begin
                  conv_wait_q <= !conv_done_in;
               end
               else
               begin
                  slot_q <= next_slot;
                  // Empty slot: channel code keeps its last legal value
                  if (next_chan <= seq_pkg::LAST_CHAN)
                  begin
                     chan_q <= next_chan;
                     soc_q <= 1'b1;
                     conv_wait_q <= 1'b1;
                  end
               end
            end
            ST_EXC:
            begin
               if (conv_wait_q)
               begin
                  conv_wait_q <= !conv_done_in;
               end
               else if (exc_left_q != 8'h00)
               begin
                  soc_q <= 1'b1;
                  conv_wait_q <= 1'b1;
                  if (!(exc_q.repeat_count_field == 3'h0 && trig_lvl))
                  begin
                     exc_left_q <= exc_left_q - 8'h01;
                  end
               end
               else
               begin
                  state_q <= ST_NORMAL;
               end
            end
            ST_SWM:
            begin
               // Conversion ending during the halt must not be lost
               if (conv_done_in)
               begin
                  conv_wait_q <= 1'b0;
               end
               if (swm_done)
               begin
                  state_q <= ST_NORMAL;
               end
            end
            default: state_q <= ST_STARTUP;
         endcase
      end
   end

   assign soc_out = soc_q;
   assign mux_chan_out = (state_q == ST_EXC) ? exc_q.chan : chan_q;
   assign exc_busy_out = fb.busy;
   assign postproc_halted_out = fb.halted;
endmodule

// >>> test/conv_model.sv
// Behavioural converter that answers each start pulse after a delay
`timescale 1ns/1ps
module conv_model
#(
   parameter int LAT = 3
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Handshake with the sequencer
   input wire logic soc_in,
   input wire logic stall_in,
   output logic done_out
);
   int cnt_q;

   // Stall holds the answer back to freeze the sequencer
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cnt_q <= 0;
         done_out <= 1'b0;
      end
      else
      begin
         done_out <= (cnt_q == 1) && !stall_in;
         if (soc_in)
            cnt_q <= LAT;
         else if (cnt_q > 1 || (cnt_q == 1 && !stall_in))
            cnt_q <= cnt_q - 1;
      end
   end
endmodule

// >>> test/seq_monitor.sv
// Port checker of the channel sequencer
`timescale 1ns/1ps
module seq_monitor
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register bus
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [2:0] pprot_in,
   input wire logic [31:0] prdata_out,
   input wire logic pslverr_out,
   input wire logic trim_en_in,
   // Converter side
   input wire logic soc_out,
   input wire logic [3:0] mux_chan_out,
   input wire logic exc_busy_out,
   input wire logic postproc_halted_out
);
   logic wr;
   logic rdx;
   logic pair;
   logic en_q;
   logic [3:0] xch_q;
   logic [7:0] lim_q;
   logic [8:0] cnt_q;
   assign wr = psel_in & penable_in & pwrite_in;
   assign rdx = psel_in & penable_in & !pwrite_in;
   assign pair = paddr_in inside {seq_pkg::OFS_SLOT_0_1,
      seq_pkg::OFS_SLOT_2_3, seq_pkg::OFS_SLOT_4_5, seq_pkg::OFS_SLOT_6_7};

   // Shadow of written setup and length of the current halt
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         {en_q, xch_q, lim_q, cnt_q} <= '0;
      end
      else
      begin
         cnt_q <= postproc_halted_out ? cnt_q + 9'h001 : 9'h000;
         if (wr && paddr_in == seq_pkg::OFS_EXC_SETUP)
            {en_q, xch_q} <= {pwdata_in[seq_pkg::EX_EN_BIT], pwdata_in[3:0]};
         if (wr && paddr_in == seq_pkg::OFS_TIME_LIMIT)
            lim_q <= pwdata_in[7:0];
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   chk_chan_range: assert property (mux_chan_out <= 4'h8)
      else $error("channel code out of range");
   chk_soc_single: assert property (soc_out |=> !soc_out)
      else $error("start pulse longer than one cycle");
   chk_busy_enabled: assert property ($rose(exc_busy_out) |-> en_q)
      else $error("exceptional run while disabled");
   chk_busy_chan: assert property (exc_busy_out && soc_out |->
      mux_chan_out == xch_q) else $error("wrong exceptional channel");
   chk_halt_limit: assert property ($rose(postproc_halted_out) |->
      lim_q != 8'h00) else $error("halt with zero limit");
   chk_halt_length: assert property ($fell(postproc_halted_out) |->
      cnt_q == {1'b0, lim_q} + 9'h002) else $error("halt length wrong");
   chk_halt_resume: assert property ($fell(postproc_halted_out) |->
      ##[0:40] soc_out) else $error("no resume after halt");
   chk_mask_refused: assert property (wr && !pprot_in[0] && !trim_en_in
      && (pair || paddr_in == seq_pkg::OFS_SLOT_8) |-> pslverr_out)
      else $error("mask write not refused");
   chk_fb_readonly: assert property (wr && paddr_in == 8'h04 |-> pslverr_out)
      else $error("feedback write not refused");
   chk_pair_zero: assert property (rdx && pair |-> prdata_out[31:25] == 7'h00
      && prdata_out[15:9] == 7'h00) else $error("pair reserved bits set");
   chk_slot8_zero: assert property (rdx && paddr_in == 8'h30 |->
      prdata_out[31:9] == 23'h000000) else $error("slot 8 reserved bits set");
endmodule

bind measurement_channel_sequencer seq_monitor u_seq_monitor (.*);

// >>> test/measurement_channel_sequencer_bench.sv
// Testbench of the channel sequencer
`timescale 1ns/1ps
module measurement_channel_sequencer_bench;
   localparam logic [7:0] FB = seq_pkg::OFS_FEEDBACK;
   localparam logic [7:0] TL = seq_pkg::OFS_TIME_LIMIT;
   logic clk_in, nrst_in, psel, penable, pwrite, trim_en, t_trig, p_clk;
   logic susp, swreq, stall, done, soc, busy, halt, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] pprot;
   logic [8:0] swmask;
   logic [3:0] mux;
   logic [7:0] ra [7];
   logic [31:0] rv [7];
   logic [3:0] xs [7];
   int bad_count, comparisons, i, n;

`define CMP(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
   bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end

   measurement_channel_sequencer u_measurement_channel_sequencer (
      .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pprot_in(pprot), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .trim_en_in(trim_en),
      .timer_trig_in(t_trig), .pump_clk_in(p_clk), .suspend_in(susp),
      .swm_req_in(swreq), .swm_mask_in(swmask), .conv_done_in(done),
      .soc_out(soc), .mux_chan_out(mux), .exc_busy_out(busy),
      .postproc_halted_out(halt));
   conv_model u_conv_model (.clk_in(clk_in), .nrst_in(nrst_in),
      .soc_in(soc), .stall_in(stall), .done_out(done));

   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic summarize;
      $display("bad_count %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic tmo;
      bad_count++;
      $display("[ERR] wait exp done got timeout");
      summarize();
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [2:0] p);
      int k;
      {psel, pwrite, paddr, pwdata, pprot} <= {1'b1, w, a, d, p};
      @(posedge clk_in);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_in);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         tmo();
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge clk_in);
   endtask

   // Wait for a start pulse, on a given channel below 9
   task automatic wsoc(input logic [3:0] ch);
      int k;
      for (k = 0; k <= 2000; k++)
      begin
         @(posedge clk_in);
         if (soc === 1'b1 && (ch > 4'h8 || mux === ch))
            break;
      end
      if (k > 2000)
         tmo();
   endtask

   // Count exceptional starts after a trigger held for hold cycles
   task automatic exc(input logic [8:0] s, input logic src, input int hold);
      int k;
      apb(1'b1, seq_pkg::OFS_EXC_SETUP,
         {19'h0, s[8:7], s[6:4], 4'h0, s[3:0]}, 3'h0);
      n = 0;
      {p_clk, t_trig} <= src ? 2'b10 : 2'b01;
      for (k = 0; k < 3000 && (k < 20 || k <= hold || busy === 1'b1); k++)
      begin
         @(posedge clk_in);
         if (k == hold)
            {p_clk, t_trig} <= 2'b00;
         if (soc === 1'b1 && busy === 1'b1)
            n++;
      end
   endtask

   initial
   begin
      {nrst_in, psel, penable, pwrite, trim_en, t_trig, p_clk} = '0;
      {susp, swreq, stall, paddr, pwdata, pprot, swmask} = '0;
      {bad_count, comparisons} = '0;
      ra = '{seq_pkg::OFS_SLOT_0_1, seq_pkg::OFS_SLOT_4_5,
         seq_pkg::OFS_SLOT_2_3, seq_pkg::OFS_SLOT_6_7, seq_pkg::OFS_SLOT_8,
         seq_pkg::OFS_EXC_SETUP, TL};
      rv = '{32'h012600df, 32'h012600de, 32'h012700de, 32'h012600df,
         32'h000000de, 32'h0, 32'h0};
      xs = '{4'h2, 4'h0, 4'h8, 4'h5, 4'h2, 4'h0, 4'h8};
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      for (i = 0; i < 7; i++)
      begin
         apb(1'b0, ra[i], 32'h0, 3'h0);
         `CMP("reset value", rv[i], rd)
      end
      apb(1'b1, ra[0], 32'h0, 3'h0);
      `CMP("user mask write", 1'b1, err)
      apb(1'b0, ra[0], 32'h0, 3'h0);
      `CMP("mask kept", rv[0], rd)
      apb(1'b1, ra[0], 32'hfe04ff20, 3'h1);
      apb(1'b0, ra[0], 32'h0, 3'h0);
      `CMP("pair masks", 32'h00040120, rd)
      trim_en <= 1'b1;
      apb(1'b1, ra[4], 32'hfffffe01, 3'h0);
      trim_en <= 1'b0;
      apb(1'b0, ra[4], 32'h0, 3'h0);
      `CMP("slot 8 mask", 32'h00000001, rd)
      for (i = 1; i < 4; i++)
         apb(1'b1, ra[i], 32'h0, 3'h1);
      apb(1'b0, 8'h3c, 32'h0, 3'h0);
      `CMP("unmapped", 1'b1, err)
      apb(1'b1, FB, 32'h0, 3'h1);
      `CMP("feedback write", 1'b1, err)
      wsoc(4'h5);
      stall <= 1'b1;
      apb(1'b0, FB, 32'h0, 3'h0);
      `CMP("active channel", 4'h5, rd[19:16])
      `CMP("active slot", 4'h0, rd[14:11])
      `CMP("busy bit", 2'b00, rd[9:8])
      stall <= 1'b0;
      for (i = 0; i < 7; i++)
      begin
         wsoc(4'hf);
         `CMP("order", xs[i], mux)
      end
      for (i = 1; i < 8; i++)
      begin
         exc({2'b01, i[2:0], i[3:0]}, 1'b0, 3);
         `CMP("repeat", 1 << i, n)
      end
      exc({2'b11, 3'h1, 4'h8}, 1'b1, 3);
      `CMP("pump trigger", 2, n)
      exc({2'b11, 3'h1, 4'h8}, 1'b0, 3);
      `CMP("timer ignored", 0, n)
      exc({2'b00, 3'h1, 4'h0}, 1'b0, 3);
      `CMP("disabled", 0, n)
      exc({2'b01, 3'h0, 4'h2}, 1'b0, 3);
      `CMP("single", 1'b1, n >= 1)
      exc({2'b01, 3'h0, 4'h2}, 1'b0, 80);
      `CMP("continuous", 1'b1, n >= 3)
      for (i = 0; i < 2; i++)
      begin
         apb(1'b1, TL, i ? 32'hff : 32'h1, 3'h0);
         {swmask, swreq} <= {9'h000, 1'b1};
         for (n = 0; n < 200 && halt !== 1'b1; n++)
            @(posedge clk_in);
         swreq <= 1'b0;
         `CMP("halted", 1'b1, halt)
         if (i)
         begin
            apb(1'b0, FB, 32'h0, 3'h0);
            `CMP("stop bit", 1'b1, rd[8])
            `CMP("cause slot", 1'b1, rd[3:0] <= 4'h8)
         end
         wsoc(4'hf);
      end
      apb(1'b1, TL, 32'h0, 3'h0);
      for (i = 0; i < 2; i++)
      begin
         {swmask, swreq} <= {i ? 9'h1ff : 9'h000, 1'b1};
         repeat (100) @(posedge clk_in);
         `CMP("no halt", 1'b0, halt)
         swreq <= 1'b0;
         apb(1'b0, FB, 32'h0, 3'h0);
         `CMP("no empty code", 1'b1, rd[3:0] !== 4'hb)
      end
      susp <= 1'b1;
      repeat (5) @(posedge clk_in);
      apb(1'b0, FB, 32'h0, 3'h0);
      `CMP("suspend code", 4'hc, rd[3:0])
      susp <= 1'b0;
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      apb(1'b0, ra[0], 32'h0, 3'h0);
      `CMP("second reset", rv[0], rd)
      summarize();
   end
endmodule
